//--- include/ems_pkg.sv
package ems_pkg;

	// ---------------------------------------------------------------
	// Widths and timing
	// ---------------------------------------------------------------
	localparam int ADDR_W   = 20;
	localparam int DATA_W   = 32;
	localparam int LANES    = 4;
	localparam int SPACES   = 4;
	localparam int SETUP_W  = 4;
	localparam int STRB_W   = 6;
	localparam int HOLD_W   = 3;
	localparam int CNT_W    = 6;
	localparam int AGE_W    = 4;
	// Strobe release after ready, in CPU periods.
	localparam int RDY_RELEASE_P = 3;
	localparam int CE_TAIL_P     = 7;
	localparam int SYNC_HALF_CYC = 2;
	localparam logic [2:0] SYNC_NOP = 3'h7;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [SETUP_W-1:0] read_setup_cycles;
		logic [STRB_W-1:0]  read_strobe_cycles;
		logic [HOLD_W-1:0]  read_hold_cycles;
		logic [SETUP_W-1:0] write_setup_cycles;
		logic [STRB_W-1:0]  write_strobe_cycles;
		logic [HOLD_W-1:0]  write_hold_cycles;
	} ems_timing_t;

	typedef struct packed {
		logic              write;
		logic              sync;
		logic              sdram;
		logic              use_ready;
		logic [1:0]        space;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  lanes;
		logic [DATA_W-1:0] wdata;
		logic [2:0]        cmd;
		logic              a10;
	} ems_req_t;

	typedef struct packed {
		logic [SPACES-1:0] sel_n;
		logic [LANES-1:0]  be_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic              doe;
		logic              oe_n;
		logic              rd_n;
		logic              wr_n;
		logic [2:0]        cmd;
		logic              a10;
		logic              mclk;
	} ems_pins_t;

	localparam ems_pins_t PINS_IDLE = '{sel_n: 4'hf, be_n: 4'hf,
		addr: 20'h0, dout: 32'h0, doe: 1'h0, oe_n: 1'h1, rd_n: 1'h1,
		wr_n: 1'h1, cmd: 3'h7, a10: 1'h0, mclk: 1'h0};

endpackage : ems_pkg

//--- design/ems_seq.sv
`timescale 1ns/10ps
module ems_seq #(
	parameter int CE_TAIL = ems_pkg::CE_TAIL_P
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        req_valid,
	input  wire ems_pkg::ems_req_t           req,
	input  wire ems_pkg::ems_timing_t [3:0]  space_timing,
	input  wire logic                        ext_ready_in,
	input  wire logic [ems_pkg::DATA_W-1:0]  ext_data_in,
	output logic                             req_ready,
	output logic                             done,
	output logic [ems_pkg::DATA_W-1:0]       read_data,
	output logic [ems_pkg::SPACES-1:0]       space_select_n,
	output logic [ems_pkg::LANES-1:0]        byte_lane_en_n,
	output logic [ems_pkg::ADDR_W-1:0]       ext_word_addr,
	output logic [ems_pkg::DATA_W-1:0]       ext_data_bus_out,
	output logic                             ext_data_bus_oe,
	output logic                             async_output_en_n,
	output logic                             async_read_strobe_n,
	output logic                             async_write_strobe_n,
	output logic                             col_or_burst_addr_strobe,
	output logic                             row_or_sync_out_en,
	output logic                             sync_write_en,
	output logic                             precharge_addr_bit,
	output logic                             mem_clock_out
);
	import ems_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, A_SETUP, A_STRB, A_EXT, A_HOLD, A_TAIL, S_PRE, S_CMD
	} ems_state_t;

	function automatic logic [CNT_W-1:0] last_idx(input logic [CNT_W-1:0] n);
		return (n == '0) ? '0 : CNT_W'(n - 1'b1);
	endfunction : last_idx

	function automatic logic [2:0] sync_cmd(input ems_req_t r);
		return r.sdram ? r.cmd : {1'b0, r.write, !r.write};
	endfunction : sync_cmd

	// ---------------------------------------------------------------
	// Ready synchroniser
	// ---------------------------------------------------------------
	// The third stage pads the path so release never beats three cycles.
	logic rdy_s1_ff, rdy_s2_ff, rdy_d_ff;
	logic nxt_rdy_s1, nxt_rdy_s2, nxt_rdy_d;

	always_comb begin
		nxt_rdy_s1 = ext_ready_in;
		nxt_rdy_s2 = rdy_s1_ff;
		nxt_rdy_d  = rdy_s2_ff;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdy_s1_ff <= 1'b0;
			rdy_s2_ff <= 1'b0;
			rdy_d_ff  <= 1'b0;
		end else begin
			rdy_s1_ff <= nxt_rdy_s1;
			rdy_s2_ff <= nxt_rdy_s2;
			rdy_d_ff  <= nxt_rdy_d;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	ems_state_t        st_ff, nxt_st;
	logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
	ems_timing_t       cfg_ff, nxt_cfg;
	ems_req_t          req_ff, nxt_req;
	ems_pins_t         p_ff, nxt_p;
	logic              ready_ff, nxt_ready;
	logic              done_ff, nxt_done;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic              ext_ff, nxt_ext;
	logic              first_ff, nxt_first;
	logic              accept;
	logic [CNT_W-1:0]  setup_n, strobe_n, hold_n;

	always_comb begin
		setup_n  = req_ff.write ? CNT_W'(cfg_ff.write_setup_cycles)
			: CNT_W'(cfg_ff.read_setup_cycles);
		strobe_n = req_ff.write ? CNT_W'(cfg_ff.write_strobe_cycles)
			: CNT_W'(cfg_ff.read_strobe_cycles);
		hold_n   = req_ff.write ? CNT_W'(cfg_ff.write_hold_cycles)
			: CNT_W'(cfg_ff.read_hold_cycles);
		accept   = req_valid && ready_ff && (!req.sync || p_ff.mclk);
		nxt_st    = st_ff;
		nxt_cnt   = CNT_W'(cnt_ff + 1'b1);
		nxt_cfg   = cfg_ff;
		nxt_req   = req_ff;
		nxt_p     = p_ff;
		nxt_p.mclk = !p_ff.mclk;
		nxt_done  = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_ext   = ext_ff;
		nxt_first = first_ff;
		case (st_ff)
			A_SETUP: begin
				if (cnt_ff == last_idx(setup_n)) begin
					nxt_st = A_STRB;
					nxt_cnt = '0;
					nxt_p.rd_n = req_ff.write;
					nxt_p.wr_n = !req_ff.write;
				end
			end
			A_STRB, A_EXT: begin
				if (st_ff == A_STRB && cnt_ff == last_idx(strobe_n)
					&& req_ff.use_ready && !rdy_d_ff) begin
					nxt_st = A_EXT;
					nxt_ext = 1'b1;
				end else if ((st_ff == A_STRB
					&& cnt_ff == last_idx(strobe_n))
					|| (st_ff == A_EXT && rdy_d_ff)) begin
					nxt_st = A_HOLD;
					nxt_cnt = '0;
					nxt_p.rd_n = 1'b1;
					nxt_p.wr_n = 1'b1;
					if (!req_ff.write)
						nxt_rdata = ext_data_in;
				end
			end
			A_HOLD: begin
				if (cnt_ff == last_idx(hold_n)) begin
					nxt_p = PINS_IDLE;
					nxt_p.mclk = !p_ff.mclk;
					nxt_p.sel_n = p_ff.sel_n;
					nxt_done = 1'b1;
					nxt_cnt = '0;
					nxt_st = (CE_TAIL == 0) ? S_IDLE : A_TAIL;
					if (CE_TAIL == 0)
						nxt_p.sel_n = '1;
				end
			end
			A_TAIL: begin
				if (cnt_ff == last_idx(CNT_W'(CE_TAIL))) begin
					nxt_st = S_IDLE;
					nxt_p.sel_n = '1;
				end
			end
			S_PRE: begin
				if (cnt_ff == CNT_W'(SYNC_HALF_CYC - 1)) begin
					nxt_st = S_CMD;
					nxt_cnt = '0;
					nxt_p.cmd = sync_cmd(req_ff);
					nxt_p.a10 = req_ff.a10;
				end
			end
			S_CMD: begin
				if (cnt_ff == CNT_W'(SYNC_HALF_CYC - 1)) begin
					nxt_st = S_IDLE;
					nxt_p = PINS_IDLE;
					nxt_p.mclk = !p_ff.mclk;
					nxt_done = 1'b1;
				end
			end
			S_IDLE: begin
				nxt_cnt = '0;
			end
			default: begin
				nxt_st = S_IDLE;
				nxt_p = PINS_IDLE;
			end
		endcase
		if (accept) begin
			nxt_req = req;
			nxt_cfg = space_timing[req.space];
			nxt_cnt = '0;
			nxt_ext = 1'b0;
			nxt_first = 1'b0;
			nxt_p.sel_n = ~(SPACES'(1) << req.space);
			nxt_p.be_n = ~req.lanes;
			nxt_p.addr = req.addr;
			nxt_p.dout = req.wdata;
			nxt_p.doe = req.write;
			nxt_p.rd_n = 1'b1;
			nxt_p.wr_n = 1'b1;
			nxt_p.oe_n = req.sync || req.write;
			nxt_p.cmd = SYNC_NOP;
			nxt_p.a10 = 1'b0;
			if (!req.sync) begin
				nxt_st = A_SETUP;
			end else if (req.write && !(st_ff == S_CMD && req_ff.sync
				&& req_ff.write)) begin
				nxt_st = S_PRE;
				nxt_first = 1'b1;
			end else begin
				nxt_st = S_CMD;
				nxt_p.cmd = sync_cmd(req);
				nxt_p.a10 = req.a10;
			end
		end
		nxt_ready = (nxt_st == S_IDLE)
			|| (nxt_st == S_CMD && nxt_cnt == CNT_W'(SYNC_HALF_CYC - 1));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff    <= S_IDLE;
			cnt_ff   <= '0;
			cfg_ff   <= '0;
			req_ff   <= '0;
			p_ff     <= PINS_IDLE;
			ready_ff <= 1'b0;
			done_ff  <= 1'b0;
			rdata_ff <= '0;
			ext_ff   <= 1'b0;
			first_ff <= 1'b0;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			cfg_ff   <= nxt_cfg;
			req_ff   <= nxt_req;
			p_ff     <= nxt_p;
			ready_ff <= nxt_ready;
			done_ff  <= nxt_done;
			rdata_ff <= nxt_rdata;
			ext_ff   <= nxt_ext;
			first_ff <= nxt_first;
		end
	end

	assign req_ready                = ready_ff;
	assign done                     = done_ff;
	assign read_data                = rdata_ff;
	assign space_select_n           = p_ff.sel_n;
	assign byte_lane_en_n           = p_ff.be_n;
	assign ext_word_addr            = p_ff.addr;
	assign ext_data_bus_out         = p_ff.dout;
	assign ext_data_bus_oe          = p_ff.doe;
	assign async_output_en_n        = p_ff.oe_n;
	assign async_read_strobe_n      = p_ff.rd_n;
	assign async_write_strobe_n     = p_ff.wr_n;
	assign col_or_burst_addr_strobe = p_ff.cmd[2];
	assign row_or_sync_out_en       = p_ff.cmd[1];
	assign sync_write_en            = p_ff.cmd[0];
	assign precharge_addr_bit       = p_ff.a10;
	assign mem_clock_out            = p_ff.mclk;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	// Phase length restarts on a strobe change or a take, not on lanes.
	logic [CNT_W-1:0] h_ff, nxt_h;
	logic [AGE_W-1:0] age_ff, nxt_age;

	always_comb begin
		nxt_h = (accept || {nxt_p.rd_n, nxt_p.wr_n}
			!= {p_ff.rd_n, p_ff.wr_n}) ? '0
			: CNT_W'(h_ff + 1'b1);
		nxt_age = !ext_ready_in ? '0
			: (&age_ff ? age_ff : AGE_W'(age_ff + 1'b1));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			h_ff   <= '0;
			age_ff <= '0;
		end else begin
			h_ff   <= nxt_h;
			age_ff <= nxt_age;
		end
	end

	rd_setup_a: assert property (@(posedge clk) disable iff (rst)
		$fell(p_ff.rd_n) |-> !p_ff.oe_n && $past(h_ff)
			== last_idx(CNT_W'(cfg_ff.read_setup_cycles)))
		else $error("read setup length wrong");
	rd_strobe_a: assert property (@(posedge clk) disable iff (rst)
		$rose(p_ff.rd_n) && !ext_ff |-> $past(h_ff)
			== last_idx(CNT_W'(cfg_ff.read_strobe_cycles)))
		else $error("read strobe length wrong");
	rd_hold_a: assert property (@(posedge clk) disable iff (rst)
		$rose(p_ff.oe_n) |-> $past(h_ff)
			== last_idx(CNT_W'(cfg_ff.read_hold_cycles)))
		else $error("read hold length wrong");
	wr_setup_a: assert property (@(posedge clk) disable iff (rst)
		$fell(p_ff.wr_n) |-> p_ff.doe && $past(h_ff)
			== last_idx(CNT_W'(cfg_ff.write_setup_cycles)))
		else $error("write setup length wrong");
	wr_strobe_a: assert property (@(posedge clk) disable iff (rst)
		$rose(p_ff.wr_n) && !ext_ff |-> $past(h_ff)
			== last_idx(CNT_W'(cfg_ff.write_strobe_cycles)))
		else $error("write strobe length wrong");
	wr_hold_a: assert property (@(posedge clk) disable iff (rst)
		$fell(p_ff.doe) && !req_ff.sync |-> $past(h_ff)
			== last_idx(CNT_W'(cfg_ff.write_hold_cycles)))
		else $error("write hold length wrong");
	rd_release_a: assert property (@(posedge clk) disable iff (rst)
		$rose(p_ff.rd_n) && ext_ff |-> $past(age_ff) inside {[3:4]})
		else $error("read release after ready out of range");
	wr_release_a: assert property (@(posedge clk) disable iff (rst)
		$rose(p_ff.wr_n) && ext_ff |-> $past(age_ff) inside {[3:4]})
		else $error("write release after ready out of range");
	ce_tail_a: assert property (@(posedge clk) disable iff (rst)
		$rose(&p_ff.be_n) |-> ##[0:7] (&p_ff.sel_n))
		else $error("chip select lingers too long");
	space_cfg_a: assert property (@(posedge clk) disable iff (rst)
		accept |=> cfg_ff == $past(space_timing[req.space]))
		else $error("timing not taken from accessed space");
	early_data_a: assert property (@(posedge clk) disable iff (rst)
		$fell(p_ff.cmd[0]) && first_ff |-> $past(p_ff.doe, 2))
		else $error("first write data not driven early");
	cmd_map_a: assert property (@(posedge clk) disable iff (rst)
		$changed(p_ff.cmd) && p_ff.cmd != SYNC_NOP
			|-> p_ff.cmd == (req_ff.sdram ? req_ff.cmd
				: {1'b0, req_ff.write, !req_ff.write}))
		else $error("command pin mapping wrong");
	sync_phase_a: assert property (@(posedge clk) disable iff (rst)
		$changed({p_ff.cmd, p_ff.a10}) |-> !p_ff.mclk)
		else $error("sync output changed in wrong phase");
	rdy_sync_a: assert property (@(posedge clk) disable iff (rst)
		$rose(rdy_d_ff) |-> $past(ext_ready_in, 3))
		else $error("ready bypassed synchroniser");

endmodule : ems_seq

//--- dv/ems_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Asynchronous memory with a ready line
// ----------------------------------------
module ems_mem_model (
	input  wire logic                       clk,
	input  wire logic [ems_pkg::SPACES-1:0] sel_n,
	input  wire logic [ems_pkg::ADDR_W-1:0] addr,
	input  wire logic [ems_pkg::DATA_W-1:0] wdata,
	input  wire logic                       oe_n,
	input  wire logic                       wr_n,
	input  wire logic [3:0]                 wait_cyc,
	output logic                            ready,
	output logic [ems_pkg::DATA_W-1:0]      rdata
);
	import ems_pkg::*;
	logic [DATA_W-1:0] mem [0:15];
	logic [DATA_W-1:0] last_ff = '0;
	logic [3:0]        cnt_ff = 4'h0;
	logic              was_sel_ff = 1'h0;
	logic              new_sel;

	// A released bus shows the inverse of its last value, so a late
	// capture by the sequencer cannot pass by luck.
	assign rdata = !oe_n ? mem[addr[3:0]] : ~last_ff;
	assign new_sel = (sel_n != 4'hf) && !was_sel_ff;
	// Ready drops on selection, as a slow part would, and comes back
	// wait_cyc+1 cycles later; a zero wait keeps it almost always high.
	assign ready = (cnt_ff == 4'h0) && !new_sel;
	always @(posedge clk) begin
		last_ff <= rdata;
		was_sel_ff <= (sel_n != 4'hf);
		cnt_ff <= new_sel ? wait_cyc : cnt_ff - {3'h0, cnt_ff != 4'h0};
	end
	always @(posedge wr_n) begin
		mem[addr[3:0]] <= wdata;
	end
endmodule : ems_mem_model

//--- dv/testbench.sv
`timescale 1ns/10ps
// ----------------------------------------
// Strobe sequencer bench
// ----------------------------------------
module testbench;
	import ems_pkg::*;
	typedef struct packed {
		logic        wr;
		logic        sync;
		logic        early;
		logic        mck;
		logic        dchk;
		logic        oe;
		logic        a10;
		logic [2:0]  cmd;
		logic [3:0]  sel;
		logic [3:0]  be;
		logic [7:0]  stp;
		logic [7:0]  stb;
		logic [7:0]  hld;
		logic [19:0] adr;
		logic [31:0] dat;
	} ems_exp_t;
	logic              clk = 1'h0;
	logic              rst = 1'h1;
	logic              req_valid = 1'h0;
	ems_req_t          req = '0;
	ems_timing_t [3:0] space_timing = '0;
	logic [3:0]        wait_cyc = 4'h0;
	logic [15:0]       lf = 16'h2d1;
	logic              ext_ready_in, req_ready, done, ext_data_bus_oe;
	logic              async_output_en_n, async_read_strobe_n;
	logic              async_write_strobe_n, col_or_burst_addr_strobe;
	logic              row_or_sync_out_en, sync_write_en;
	logic              precharge_addr_bit, mem_clock_out;
	logic [3:0]        space_select_n, byte_lane_en_n;
	logic [19:0]       ext_word_addr;
	logic [31:0]       ext_data_in, read_data, ext_data_bus_out;
	logic [31:0]       shadow [0:15];
	logic [2:0]        cmd_pins;
	logic              doe_p1 = 1'h0;
	logic              doe_p2 = 1'h0;
	logic              cap;
	ems_exp_t          sn, ex;
	ems_exp_t          exp_q [$];
	int                fails = 0;
	int                cmp_count = 0;

	assign cmd_pins = {col_or_burst_addr_strobe, row_or_sync_out_en,
		sync_write_en};
	always #20 clk = ~clk;

	ems_seq u_dut (
		.clk, .rst, .req_valid, .req, .space_timing, .ext_ready_in,
		.ext_data_in, .req_ready, .done, .read_data, .space_select_n,
		.byte_lane_en_n, .ext_word_addr, .ext_data_bus_out,
		.ext_data_bus_oe, .async_output_en_n, .async_read_strobe_n,
		.async_write_strobe_n, .col_or_burst_addr_strobe,
		.row_or_sync_out_en, .sync_write_en, .precharge_addr_bit,
		.mem_clock_out
	);
	ems_mem_model u_mem (
		.clk, .sel_n(space_select_n), .addr(ext_word_addr),
		.wdata(ext_data_bus_out), .oe_n(async_output_en_n),
		.wr_n(async_write_strobe_n), .wait_cyc, .ready(ext_ready_in),
		.rdata(ext_data_in)
	);

	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : rnd

	function automatic logic [7:0] mx1(input logic [7:0] x);
		return (x == 8'h0) ? 8'h1 : x;
	endfunction : mx1

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic prog(input logic ext);
		ems_timing_t t;
		for (int s = 0; s < 4; s++) begin
			t = ems_timing_t'(26'({rnd(), rnd()}));
			if (ext) begin
				t.read_setup_cycles = {3'h0, t.read_setup_cycles[0]} + 4'h1;
				t.write_setup_cycles = {3'h0, t.write_setup_cycles[0]} + 4'h1;
				t.read_strobe_cycles = {4'h0, t.read_strobe_cycles[1:0]} + 6'h3;
				t.write_strobe_cycles = {4'h0, t.write_strobe_cycles[1:0]} + 6'h3;
			end
			space_timing[s] <= t;
		end
	endtask : prog

	task automatic acc(input logic wr, input logic sy, input logic sd,
		input logic ur, input logic [3:0] a);
		ems_req_t    r;
		ems_exp_t    e;
		ems_timing_t t;
		logic [15:0] x;
		int          n;
		x = rnd();
		r = '0;
		r.write = wr;
		r.sync = sy;
		r.sdram = sd;
		r.use_ready = ur;
		r.space = x[1:0];
		r.lanes = x[5:2];
		r.a10 = x[6];
		r.addr = {16'h0, a};
		r.wdata = {rnd(), rnd()};
		r.cmd = wr ? 3'h2 : 3'h3;
		t = space_timing[r.space];
		e = '0;
		e.wr = wr;
		e.sync = sy;
		e.cmd = SYNC_NOP;
		e.sel = ~(4'h1 << r.space);
		e.be = ~r.lanes;
		e.adr = r.addr;
		e.dat = wr ? r.wdata : shadow[a];
		e.dchk = wr | !sy;
		if (sy) begin
			e.cmd = sd ? r.cmd : {1'h0, wr, !wr};
			e.early = wr;
			e.a10 = r.a10;
		end else begin
			e.oe = wr;
			e.stp = mx1(wr ? t.write_setup_cycles : t.read_setup_cycles);
			e.stb = mx1(wr ? t.write_strobe_cycles : t.read_strobe_cycles);
			e.hld = mx1(wr ? t.write_hold_cycles : t.read_hold_cycles);
			if (wr)
				shadow[a] = r.wdata;
		end
		n = ur ? int'(e.stp) + int'(e.stb) : 0;
		if (ur)
			e.stb = 8'(n + 5) - e.stp;
		wait_cyc <= 4'(n);
		exp_q.push_back(e);
		req <= r;
		req_valid <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(req_ready === 1'h1 && (!sy || mem_clock_out === 1'h1))
			&& n < 500);
		req_valid <= 1'h0;
		while (exp_q.size() != 0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (exp_q.size() != 0) begin
			fails++;
			$display("wrong value done expected 1 seen 0");
			close_out();
		end
	endtask : acc

	always @(posedge clk) begin
		if (done === 1'h1 && !rst) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("wrong value done expected 0 seen 1");
			end else begin
				ex = exp_q.pop_front();
				if (!ex.wr && !ex.sync)
					sn.dat = read_data;
				check("setup", ex.sync ? 8'h0 : sn.stp, ex.stp);
				check("strobe", sn.stb, ex.stb);
				check("hold", sn.hld, ex.hld);
				check("select", sn.sel, ex.sel);
				check("lanes", sn.be, ex.be);
				check("address", sn.adr, ex.adr);
				check("command", sn.cmd, ex.cmd);
				check("early data", sn.early, ex.early);
				check("clock phase", sn.mck, ex.mck);
				check("precharge bit", sn.a10, ex.a10);
				check("output enable", sn.oe, ex.oe);
				if (ex.dchk)
					check("data", sn.dat, ex.dat);
			end
		end
		if (rst || done === 1'h1 || space_select_n === 4'hf) begin
			sn = '0;
			sn.cmd = SYNC_NOP;
		end else begin
			cap = cmd_pins != SYNC_NOP && !sn.sync;
			if (cap) begin
				sn.sync = 1'h1;
				sn.cmd = cmd_pins;
				sn.early = doe_p2;
				sn.mck = mem_clock_out;
				sn.a10 = precharge_addr_bit;
			end
			if ((async_read_strobe_n & async_write_strobe_n) === 1'h0) begin
				sn.stb++;
				sn.wr = 1'h1;
				sn.oe = async_output_en_n;
				cap = 1'h1;
			end else if (sn.wr)
				sn.hld++;
			else
				sn.stp++;
			if (cap) begin
				sn.sel = space_select_n;
				sn.be = byte_lane_en_n;
				sn.adr = ext_word_addr;
				sn.dat = ext_data_bus_out;
			end
		end
		doe_p2 = doe_p1;
		doe_p1 = ext_data_bus_oe;
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			prog(1'h0);
			@(posedge clk);
			acc(1'h1, 1'h0, 1'h0, 1'h0, 4'(i));
			acc(1'h0, 1'h0, 1'h0, 1'h0, 4'(i));
		end
		$display("test async plain finished");
		for (int i = 0; i < 3; i++) begin
			prog(1'h1);
			@(posedge clk);
			acc(1'h1, 1'h0, 1'h0, 1'h1, 4'(i + 8));
			acc(1'h0, 1'h0, 1'h0, 1'h1, 4'(i + 8));
		end
		$display("test async ready finished");
		for (int k = 0; k < 8; k++)
			acc(k[0], 1'h1, k[1], 1'h0, 4'(k));
		$display("test sync commands finished");
		close_out();
	end
endmodule : testbench
